// ### mdc_pkg_sync.sv
// constants package and pin input synchroniser for the converter front end
package mdc_pkg;
   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [3:0] MDC_CTRL_OFF      = 4'h0;
   localparam logic [3:0] MDC_STAT_OFF      = 4'h4;
   // ------------------------------------------------------------------
   // control fields
   // ------------------------------------------------------------------
   localparam int         MDC_RATIO_POS     = 0;
   localparam int         MDC_CLOCK_DIVISION_SELECT_POS      = 1;
   localparam int         MDC_PSS_POS       = 3;
   localparam int         MDC_MODE_POS      = 6;
   localparam int         MDC_INPUT_UNDERCLOCK_MODE_POS      = 8;
   localparam logic [8:0] MDC_CTRL_RST      = 9'h1c0;
   // ------------------------------------------------------------------
   // status fields
   // ------------------------------------------------------------------
   localparam int         MDC_SETUP_POS     = 0;
   localparam int         MDC_HOLD_POS      = 1;
   localparam int         MDC_SYNC_POS      = 2;
   localparam int         MDC_BADDIV_POS    = 3;
   localparam int         MDC_LIVE_SU_POS   = 4;
   localparam int         MDC_LIVE_HD_POS   = 5;
   localparam logic [3:0] MDC_STAT_RST      = 4'h0;
   // ------------------------------------------------------------------
   // frame geometry
   // ------------------------------------------------------------------
   localparam int         MDC_WORD_W        = 10;
   localparam int         MDC_PORTS         = 4;
   localparam int         MDC_PIN_STAGES    = 3;
   localparam int         MDC_PSS_TAPS      = 4;

   typedef enum logic [1:0] {
      MDC_MODE_NRZ  = 2'b00,
      MDC_MODE_NARROW_RETURN_ZERO_MODE = 2'b01,
      MDC_MODE_RTZ  = 2'b10,
      MDC_MODE_RF   = 2'b11
   } mdc_mode_t;

   typedef enum logic [1:0] {
      MDC_DIV_ONE   = 2'b00,
      MDC_DIV_TWO   = 2'b01,
      MDC_DIV_BAD_A = 2'b10,
      MDC_DIV_BAD_B = 2'b11
   } mdc_div_t;

   typedef enum logic {
      MDC_BUS_IDLE  = 1'b0,
      MDC_BUS_ACK   = 1'b1
   } mdc_bus_t;
endpackage : mdc_pkg

`timescale 1ns/100ps
module mdc_pin_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // raw pins and settled value
   input  wire logic [WIDTH-1:0] pin_raw,
   output logic      [WIDTH-1:0] pin_settled
);
   logic [WIDTH-1:0] st1_q;
   logic [WIDTH-1:0] st2_q;
   logic [WIDTH-1:0] st3_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st1_q <= '0;
         st2_q <= '0;
         st3_q <= '0;
      end else begin
         st1_q <= pin_raw;
         st2_q <= st1_q;
         st3_q <= st2_q;
      end
   end

   // a change counts once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge core_clk) begin
            if (rst) begin
               pin_settled[g] <= 1'b0;
            end else if (st2_q[g] == st3_q[g]) begin
               pin_settled[g] <= st3_q[g];
            end
         end
      end
   endgenerate
endmodule : mdc_pin_sync

// ### mdc_front.sv
// multiplexing converter front end: serialiser, forwarded clock, timing check
`timescale 1ns/100ps
module mdc_front
   import mdc_pkg::*;
#(
   parameter int WORD_W = mdc_pkg::MDC_WORD_W
) (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   // avalon-mm slave
   input  wire logic [3:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   // parallel input ports from the fpga
   input  wire logic [WORD_W-1:0]     port_a,
   input  wire logic [WORD_W-1:0]     port_b,
   input  wire logic [WORD_W-1:0]     port_c,
   input  wire logic [WORD_W-1:0]     port_d,
   input  wire logic                  data_check_p,
   input  wire logic                  sync_pair,
   // forwarded clock and timing flags
   output logic                       fwd_data_clock_p,
   output logic                       fwd_data_clock_n,
   output logic                       setup_violation_flag,
   output logic                       hold_violation_flag,
   // converter core side
   output logic      [WORD_W-1:0]     core_sample,
   output mdc_pkg::mdc_mode_t         output_mode,
   output logic                       input_underclock_mode
);
   import mdc_pkg::*;

   localparam int PW = MDC_PORTS * WORD_W + 2;

   // ------------------------------------------------------------------
   // pin synchronisation
   // ------------------------------------------------------------------
   logic [PW-1:0]     pins_settled;
   logic [WORD_W-1:0] in_word [MDC_PORTS];
   logic              check_s;
   logic              sync_s;
   logic              sync_prev_q;
   logic              sync_rise;

   mdc_pin_sync #(
      .WIDTH       (PW)
   ) u_pins (
      .core_clk    (core_clk),
      .rst         (rst),
      .pin_raw     ({sync_pair, data_check_p, port_d, port_c, port_b, port_a}),
      .pin_settled (pins_settled)
   );

   genvar gp;
   generate
      for (gp = 0; gp < MDC_PORTS; gp++) begin : g_port
         assign in_word[gp] = pins_settled[gp*WORD_W +: WORD_W];
      end
   endgenerate

   assign check_s = pins_settled[PW-2];
   assign sync_s  = pins_settled[PW-1];

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync_prev_q <= 1'b0;
      end else begin
         sync_prev_q <= sync_s;
      end
   end

   assign sync_rise = sync_s & ~sync_prev_q;

   // ------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------
   logic [8:0]        ctrl_q;
   logic              ratio_two;
   mdc_div_t          div_sel;
   logic              div_two;
   logic              div_bad;
   logic [2:0]        phase_shift_select;
   logic              bus_wr;
   logic              bus_rd;
   mdc_bus_t          bus_q;

   assign ratio_two             = ctrl_q[MDC_RATIO_POS];
   assign div_sel               = mdc_div_t'(ctrl_q[MDC_CLOCK_DIVISION_SELECT_POS +: 2]);
   assign phase_shift_select                   = ctrl_q[MDC_PSS_POS +: 3];
   assign output_mode           = mdc_mode_t'(ctrl_q[MDC_MODE_POS +: 2]);
   assign input_underclock_mode = ctrl_q[MDC_INPUT_UNDERCLOCK_MODE_POS];

   // codes 10 and 11 are refused: run at factor one, flag in status
   always_comb begin
      div_two = 1'b0;
      div_bad = 1'b0;
      unique case (div_sel)
         MDC_DIV_ONE:   div_two = 1'b0;
         MDC_DIV_TWO:   div_two = 1'b1;
         MDC_DIV_BAD_A: div_bad = 1'b1;
         MDC_DIV_BAD_B: div_bad = 1'b1;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_q <= MDC_CTRL_RST;
      end else if (bus_wr && avs_address == MDC_CTRL_OFF) begin
         if (avs_byteenable[0]) begin
            ctrl_q[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            ctrl_q[8] <= avs_writedata[8];
         end
      end
   end

   // ------------------------------------------------------------------
   // frame sequencing
   // ------------------------------------------------------------------
   logic              sub_q;
   logic [1:0]        idx_q;
   logic              frm_q;
   logic              clk_base_q;
   logic              last_sub;
   logic              last_idx;
   logic              last_frm;
   logic              frame_end;
   logic              mid_point;

   // under-clocking holds each sample for two sampling cycles
   assign last_sub  = (sub_q == input_underclock_mode);
   assign last_idx  = (idx_q == (ratio_two ? 2'h1 : 2'h3));
   assign last_frm  = (frm_q == div_two);
   assign frame_end = last_sub & last_idx;
   // sample the check line one cycle before the frame ends, after it has settled
   assign mid_point = input_underclock_mode ? (last_idx & ~sub_q)
                                            : (idx_q == (ratio_two ? 2'h0 : 2'h2));

   always_ff @(posedge core_clk) begin
      if (rst || sync_rise) begin
         sub_q <= 1'b0;
      end else begin
         sub_q <= last_sub ? 1'b0 : ~sub_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || sync_rise) begin
         idx_q <= 2'h0;
      end else if (frame_end) begin
         idx_q <= 2'h0;
      end else if (last_sub) begin
         idx_q <= idx_q + 2'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || sync_rise) begin
         frm_q <= 1'b0;
      end else if (frame_end) begin
         frm_q <= last_frm ? 1'b0 : ~frm_q;
      end
   end

   // one half period per frame at factor one, so words move on both edges
   always_ff @(posedge core_clk) begin
      if (rst || sync_rise) begin
         clk_base_q <= 1'b0;
      end else if (frame_end && last_frm) begin
         clk_base_q <= ~clk_base_q;
      end
   end

   // ------------------------------------------------------------------
   // phase shift of the forwarded clock
   // ------------------------------------------------------------------
   logic [MDC_PSS_TAPS-1:0] dly_q;
   logic                    tap;
   logic                    half_q;
   logic                    fwd_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         dly_q <= '0;
      end else begin
         dly_q <= {dly_q[MDC_PSS_TAPS-2:0], clk_base_q};
      end
   end

   // whole cycles from the upper bits, half cycle from the falling edge
   always_comb begin
      tap = clk_base_q;
      unique case (phase_shift_select[2:1])
         2'h0: tap = dly_q[0];
         2'h1: tap = dly_q[1];
         2'h2: tap = dly_q[2];
         2'h3: tap = dly_q[3];
      endcase
   end

   always_ff @(negedge core_clk) begin
      if (rst) begin
         half_q <= 1'b0;
      end else begin
         half_q <= fwd_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         fwd_q <= 1'b0;
      end else begin
         fwd_q <= tap;
      end
   end

   assign fwd_data_clock_p = phase_shift_select[0] ? half_q : fwd_q;
   assign fwd_data_clock_n = ~fwd_data_clock_p;

   // ------------------------------------------------------------------
   // serialiser
   // ------------------------------------------------------------------
   logic [WORD_W-1:0] hold_q [MDC_PORTS];
   logic [WORD_W-1:0] next_word;

   genvar gh;
   generate
      for (gh = 0; gh < MDC_PORTS; gh++) begin : g_hold
         always_ff @(posedge core_clk) begin
            if (rst) begin
               hold_q[gh] <= '0;
            end else if (frame_end) begin
               // upper ports stay cleared in two-to-one
               hold_q[gh] <= (ratio_two && gh >= 2) ? '0 : in_word[gh];
            end
         end
      end
   endgenerate

   always_comb begin
      next_word = hold_q[0];
      unique case (idx_q)
         2'h0: next_word = hold_q[0];
         2'h1: next_word = hold_q[1];
         2'h2: next_word = hold_q[2];
         2'h3: next_word = hold_q[3];
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         core_sample <= '0;
      end else begin
         core_sample <= next_word;
      end
   end

   // ------------------------------------------------------------------
   // timing check on the toggling check line
   // ------------------------------------------------------------------
   logic              mid_chk_q;
   logic              su_live_q;
   logic              hd_live_q;
   logic              chk_armed_q;

   always_ff @(posedge core_clk) begin
      if (rst || sync_rise) begin
         mid_chk_q   <= 1'b0;
         chk_armed_q <= 1'b0;
         su_live_q   <= 1'b0;
      end else if (mid_point) begin
         mid_chk_q   <= check_s;
         chk_armed_q <= 1'b1;
         // no toggle since the last mid point: data arrives late
         su_live_q   <= chk_armed_q & (check_s == mid_chk_q);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || sync_rise) begin
         hd_live_q <= 1'b0;
      end else if (frame_end) begin
         // line moved before the window closed: data left too early
         hd_live_q <= chk_armed_q & (check_s != mid_chk_q);
      end
   end

   assign setup_violation_flag = su_live_q;
   assign hold_violation_flag  = hd_live_q;

   // ------------------------------------------------------------------
   // sticky status, write one to clear, set wins
   // ------------------------------------------------------------------
   logic [3:0]        stat_q;
   logic [3:0]        stat_set;
   logic [3:0]        stat_clr;

   assign stat_set = {div_bad, sync_rise, hd_live_q, su_live_q};
   assign stat_clr = (bus_wr && avs_address == MDC_STAT_OFF && avs_byteenable[0])
                     ? avs_writedata[3:0] : 4'h0;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stat_q <= MDC_STAT_RST;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | stat_set;
      end
   end

   // ------------------------------------------------------------------
   // avalon-mm slave: one wait cycle, answer on the second
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bus_q <= MDC_BUS_IDLE;
      end else begin
         unique case (bus_q)
            MDC_BUS_IDLE: bus_q <= (avs_read || avs_write) ? MDC_BUS_ACK : MDC_BUS_IDLE;
            MDC_BUS_ACK:  bus_q <= MDC_BUS_IDLE;
         endcase
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && (bus_q == MDC_BUS_IDLE);
   assign bus_wr          = avs_write && (bus_q == MDC_BUS_ACK);
   assign bus_rd          = avs_read && (bus_q == MDC_BUS_IDLE);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         avs_readdata <= 32'h0;
      end else if (bus_rd) begin
         unique case (avs_address)
            MDC_CTRL_OFF: avs_readdata <= {23'h0, ctrl_q};
            MDC_STAT_OFF: avs_readdata <= {26'h0, hd_live_q, su_live_q, stat_q};
            default:      avs_readdata <= 32'h0;
         endcase
      end
   end
endmodule : mdc_front

// ### mdc_front_properties.sv
// bound checker for the converter front end
`timescale 1ns/100ps
module mdc_front_properties
   import mdc_pkg::*;
#(
   parameter int WORD_W = 10
) (
   // clock and reset
   input wire logic              core_clk,
   input wire logic              rst,
   // avalon-mm slave
   input wire logic [3:0]        avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_writedata,
   input wire logic [3:0]        avs_byteenable,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   // pins
   input wire logic              sync_pair,
   input wire logic              fwd_data_clock_p,
   input wire logic              fwd_data_clock_n,
   input wire logic [WORD_W-1:0] core_sample,
   input wire mdc_pkg::mdc_mode_t output_mode,
   input wire logic              input_underclock_mode
);
   logic [8:0] ctl_q;
   logic [7:0] quiet_q;
   logic [4:0] cnt_q;
   logic       prev_q;
   logic       wr_ctl;
   logic [4:0] half;
   // ------------------------------------------------------------------
   // shadow of the control word and toggle spacing
   // ------------------------------------------------------------------
   assign wr_ctl = avs_write && !avs_waitrequest && avs_address == MDC_CTRL_OFF;
   assign half = 5'((ctl_q[0] ? 2 : 4) * (ctl_q[8] ? 2 : 1) * (ctl_q[2:1] == 2'b01 ? 2 : 1));
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctl_q <= MDC_CTRL_RST;
      end else if (wr_ctl) begin
         if (avs_byteenable[0]) ctl_q[7:0] <= avs_writedata[7:0];
         if (avs_byteenable[1]) ctl_q[8] <= avs_writedata[8];
      end
   end
   always_ff @(posedge core_clk) begin
      prev_q  <= fwd_data_clock_p;
      cnt_q   <= (fwd_data_clock_p != prev_q) ? 5'h1 : cnt_q + 5'h1;
      quiet_q <= (rst || wr_ctl || sync_pair) ? 8'h0 : quiet_q + {7'h0, quiet_q != 8'hff};
   end
   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   clk_pair_a: assert property (fwd_data_clock_n == !fwd_data_clock_p)
      else $error("forwarded clock pair not complementary");
   half_period_a: assert property (fwd_data_clock_p != prev_q && quiet_q == 8'hff |-> cnt_q == half)
      else $error("forwarded clock half period wrong");
   mode_follow_a: assert property (quiet_q > 8'h1 |-> output_mode == ctl_q[7:6])
      else $error("waveform mode differs from control word");
   input_underclock_mode_follow_a: assert property (quiet_q > 8'h1 |-> input_underclock_mode == ctl_q[8])
      else $error("under-clock mode differs from control word");
   reset_val_a: assert property ($fell(rst) |-> output_mode == MDC_MODE_RF && !fwd_data_clock_p)
      else $error("wrong values after reset");
   ctrl_read_a: assert property (avs_read && !avs_waitrequest && avs_address == MDC_CTRL_OFF |-> avs_readdata == {23'h0, ctl_q})
      else $error("control readback wrong");
   one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("more than one wait cycle");
   first_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("no wait cycle on new request");
   hold_sample_a: assert property (input_underclock_mode && quiet_q == 8'hff && $changed(core_sample) |=> $stable(core_sample))
      else $error("sample stood one cycle in under-clock mode");
endmodule : mdc_front_properties

bind mdc_front mdc_front_properties #(.WORD_W(WORD_W)) chk_u (.core_clk, .rst, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .sync_pair, .fwd_data_clock_p, .fwd_data_clock_n, .core_sample, .output_mode,
   .input_underclock_mode);

// ### mdc_fpga_model.sv
// fpga model launching tagged sample words from the forwarded clock
`timescale 1ns/100ps
module mdc_fpga_model (
   // clocks
   input  wire logic       core_clk,
   input  wire logic       fwd_data_clock_p,
   // test controls
   input  wire logic       float_cd,
   input  wire logic       freeze_check,
   // launched words
   output logic      [9:0] port_a,
   output logic      [9:0] port_b,
   output logic      [9:0] port_c,
   output logic      [9:0] port_d,
   output logic            data_check_p
);
   logic [7:0] frame_q = 8'h0;
   logic [9:0] junk_q = 10'h0;
   logic       chk_q = 1'b0;
   // one frame launched on each edge of the forwarded clock
   always @(fwd_data_clock_p) begin
      frame_q <= frame_q + 8'h1;
      if (!freeze_check) chk_q <= !chk_q;
   end
   // open pins show a pattern that flips every cycle
   always @(posedge core_clk) junk_q <= ~junk_q;
   assign port_a = {frame_q, 2'h0};
   assign port_b = {frame_q, 2'h1};
   assign port_c = float_cd ? junk_q : {frame_q, 2'h2};
   assign port_d = float_cd ? ~junk_q : {frame_q, 2'h3};
   assign data_check_p = chk_q;
endmodule : mdc_fpga_model

// ### mdc_front_tb.sv
// self-checking bench for the converter front end
`timescale 1ns/100ps
module mdc_front_tb;
   import mdc_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [9:0]  port_a, port_b, port_c, port_d, core_sample;
   logic        data_check_p, fwd_data_clock_p, fwd_data_clock_n;
   logic        setup_violation_flag, hold_violation_flag, input_underclock_mode;
   logic        sync_pair = 1'b0;
   logic        float_cd = 1'b0;
   logic        freeze_check = 1'b0;
   mdc_mode_t   output_mode;
   int          bad_count = 0;
   int          checks = 0;
   logic [31:0] rd;
   realtime     rise_t = 0.0;

   always #5 core_clk = ~core_clk;
   always @(posedge fwd_data_clock_p) rise_t = $realtime;

   mdc_front dut_u (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .port_a, .port_b, .port_c, .port_d,
      .data_check_p, .sync_pair, .fwd_data_clock_p, .fwd_data_clock_n, .setup_violation_flag,
      .hold_violation_flag, .core_sample, .output_mode, .input_underclock_mode);
   mdc_fpga_model fpga_u (.core_clk, .fwd_data_clock_p, .float_cd, .freeze_check, .port_a,
      .port_b, .port_c, .port_d, .data_check_p);

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         bad_count++;
         $display("Error %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic give_verdict();
      if (bad_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic fail_wait();
      bad_count++;
      $display("Error %0t: wait ran out", $time);
      give_verdict();
   endtask : fail_wait
   task automatic ticks(input int n);
      repeat (n) @(posedge core_clk);
   endtask : ticks
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) fail_wait();
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wait_flip(output int n);
      logic p;
      n = 0;
      p = fwd_data_clock_p;
      do begin
         @(negedge core_clk);
         n++;
      end while (fwd_data_clock_p === p && n < 100);
      if (n >= 100) fail_wait();
   endtask : wait_flip
   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic s_reset();
      ticks(260);
      check({30'h0, output_mode}, {30'h0, MDC_MODE_RF});
      bus(1'b1, 4'h8, 32'h3f, 4'hf);
      bus(1'b0, 4'h8, 32'h0, 4'hf);
      check(rd, 32'h0);
      bus(1'b0, MDC_CTRL_OFF, 32'h0, 4'hf);
      check(rd, {23'h0, MDC_CTRL_RST});
   endtask : s_reset
   task automatic s_period();
      logic [8:0] cfg [6] = '{9'h000, 9'h041, 9'h082, 9'h1c0, 9'h003, 9'h044};
      int half [6] = '{4, 2, 8, 8, 4, 4};
      int n;
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, MDC_CTRL_OFF, {23'h0, cfg[i]}, 4'hf);
         wait_flip(n);
         wait_flip(n);
         wait_flip(n);
         check(n, half[i]);
         check({30'h0, output_mode}, {30'h0, cfg[i][7:6]});
      end
      bus(1'b0, MDC_STAT_OFF, 32'h0, 4'hf);
      check(rd[MDC_BADDIV_POS], 1'b1);
      bus(1'b1, MDC_CTRL_OFF, 32'h0, 4'hf);
      bus(1'b1, MDC_STAT_OFF, 32'hf, 4'h1);
      bus(1'b0, MDC_STAT_OFF, 32'h0, 4'hf);
      check(rd[MDC_BADDIV_POS], 1'b0);
   endtask : s_period
   task automatic s_phase();
      int ph0 = 0;
      int ph;
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, MDC_CTRL_OFF, 32'(k) << 3, 4'hf);
         ticks(30);
         ph = int'(rise_t * 10) % 800;
         if (k == 0) ph0 = ph;
         check((ph - ph0 + 800) % 800, k * 50);
      end
   endtask : s_phase
   task automatic s_data(input logic ratio);
      int n = 0;
      int slots;
      logic [7:0] tag;
      slots = ratio ? 2 : 4;
      float_cd <= ratio;
      bus(1'b1, MDC_CTRL_OFF, {31'h0, ratio}, 4'hf);
      ticks(40);
      do begin
         @(negedge core_clk);
         n++;
      end while (core_sample[1:0] !== 2'h0 && n < 20);
      if (n >= 20) fail_wait();
      tag = core_sample[9:2];
      for (int s = 1; s <= slots; s++) begin
         @(negedge core_clk);
         check(core_sample, {(s == slots) ? tag + 8'h1 : tag, 2'(s % slots)});
      end
   endtask : s_data
   task automatic s_flags();
      ticks(8);
      check(setup_violation_flag, 1'b0);
      check(hold_violation_flag, 1'b0);
      freeze_check <= 1'b1;
      ticks(60);
      check(setup_violation_flag, 1'b1);
      check(hold_violation_flag, 1'b0);
      bus(1'b0, MDC_STAT_OFF, 32'h0, 4'hf);
      check(rd[MDC_SETUP_POS], 1'b1);
      freeze_check <= 1'b0;
      sync_pair <= 1'b1;
      ticks(8);
      sync_pair <= 1'b0;
      ticks(8);
      bus(1'b0, MDC_STAT_OFF, 32'h0, 4'hf);
      check(rd[MDC_SYNC_POS], 1'b1);
      bus(1'b1, MDC_STAT_OFF, 32'h4, 4'h1);
      bus(1'b0, MDC_STAT_OFF, 32'h0, 4'hf);
      check(rd[MDC_SYNC_POS], 1'b0);
   endtask : s_flags

   initial begin
      ticks(16);
      rst <= 1'b0;
      s_reset();
      s_period();
      s_phase();
      s_data(1'b0);
      s_data(1'b1);
      s_flags();
      give_verdict();
   end
endmodule : mdc_front_tb
